// ==== crossing_regs.svh ====
// register offsets, field positions, reset values for the crossing detector
`ifndef CROSSING_REGS_SVH
`define CROSSING_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CTRL_OFS 4'h0
`define FLAGS_OFS 4'h4
`define ENABLES_OFS 4'h8
`define IRQCTL_OFS 4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_EN_BIT 7
`define CTRL_OUT_BIT 5
`define CTRL_INV_BIT 4
`define CTRL_RISE_BIT 1
`define CTRL_FALL_BIT 0
`define FLAG_BIT 6
`define IRQ_GLOBAL_BIT 7
`define IRQ_PERIPH_BIT 6

// ----------------------------------------------------------------
// reset values and synchroniser depth
// ----------------------------------------------------------------
`define CTRL_RST 8'h00
`define SYNC_STAGES 2

`endif

// ==== crossing_pkg.sv ====
// types shared by the crossing detector
package crossing_pkg;

  typedef struct packed {
    logic [1:0] sync;
    logic out_prev;
    logic enable;
    logic invert;
    logic rise_en;
    logic fall_en;
    logic flag;
    logic flag_ie;
    logic periph_gate;
    logic global_gate;
    logic ack;
    logic [31:0] rdata;
    logic strap_seen;
  } state_s;

endpackage

// ==== zero_crossing_event_logic.sv ====
// crossing detector digital logic with wishbone register slave
`timescale 1ns/1ps
`include "crossing_regs.svh"

module zero_crossing_event_logic (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sink_active_i,
  input wire logic detector_default_off_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic detector_enable_o,
  output logic crossing_logic_out_o,
  output logic irq_o,
  output logic wake_o
);

  crossing_pkg::state_s s_r;
  crossing_pkg::state_s s_nxt;
  logic logic_out;
  logic rise_evt;
  logic fall_evt;
  logic req;
  logic wr0;

  // ----------------------------------------------------------------
  // polarity and edge detection
  // ----------------------------------------------------------------

  // polarity adjust acts regardless of enable
  assign logic_out = s_r.sync[1] ^ s_r.invert;
  // two independent detectors on the adjusted output
  assign rise_evt = logic_out & ~s_r.out_prev;
  assign fall_evt = ~logic_out & s_r.out_prev;

  assign req = cyc_i & stb_i & ~s_r.ack;
  // a write commits at the edge where ack stands, with the request still held
  assign wr0 = cyc_i & stb_i & we_i & sel_i[0] & s_r.ack;

  // read mux for one register offset
  function automatic logic [31:0] read_reg(input logic [3:0] a,
                                           input crossing_pkg::state_s st,
                                           input logic lo);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `CTRL_OFS: begin
        v[`CTRL_EN_BIT] = st.enable;
        v[`CTRL_OUT_BIT] = lo;
        v[`CTRL_INV_BIT] = st.invert;
        v[`CTRL_RISE_BIT] = st.rise_en;
        v[`CTRL_FALL_BIT] = st.fall_en;
      end
      `FLAGS_OFS: v[`FLAG_BIT] = st.flag;
      `ENABLES_OFS: v[`FLAG_BIT] = st.flag_ie;
      `IRQCTL_OFS: begin
        v[`IRQ_GLOBAL_BIT] = st.global_gate;
        v[`IRQ_PERIPH_BIT] = st.periph_gate;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // synchroniser, edge history, register writes, sticky flag
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], sink_active_i};
    s_nxt.out_prev = logic_out;
    s_nxt.ack = req;
    s_nxt.strap_seen = 1'b1;
    if (!s_r.strap_seen) begin
      s_nxt.enable = ~detector_default_off_i;
    end
    if (req && !we_i) begin
      s_nxt.rdata = read_reg(adr_i, s_r, logic_out);
    end
    if (wr0) begin
      unique case (adr_i)
        `CTRL_OFS: begin
          s_nxt.enable = dat_i[`CTRL_EN_BIT];
          s_nxt.invert = dat_i[`CTRL_INV_BIT];
          s_nxt.rise_en = dat_i[`CTRL_RISE_BIT];
          s_nxt.fall_en = dat_i[`CTRL_FALL_BIT];
        end
        `FLAGS_OFS: begin
          if (dat_i[`FLAG_BIT]) begin
            s_nxt.flag = 1'b0;
          end
        end
        `ENABLES_OFS: s_nxt.flag_ie = dat_i[`FLAG_BIT];
        `IRQCTL_OFS: begin
          s_nxt.global_gate = dat_i[`IRQ_GLOBAL_BIT];
          s_nxt.periph_gate = dat_i[`IRQ_PERIPH_BIT];
        end
        default: s_nxt.flag = s_r.flag;
      endcase
    end
    // set after clear so a coincident edge wins; no clock gating in sleep
    if ((rise_evt && s_r.rise_en) || (fall_evt && s_r.fall_en)) begin
      s_nxt.flag = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  assign dat_o = s_r.rdata;
  assign ack_o = s_r.ack;
  assign detector_enable_o = s_r.enable;
  assign crossing_logic_out_o = logic_out;
  // all three gates plus the flag
  assign irq_o = s_r.flag & s_r.flag_ie & s_r.periph_gate & s_r.global_gate;
  assign wake_o = s_r.flag & s_r.flag_ie;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  a_out_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
    |-> crossing_logic_out_o == ($past(sink_active_i, 2) ^ s_r.invert))
    else $error("status bit does not follow polarity");

  a_sync_depth: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) == 1'b0 ##0 $past(rst_i, 2) == 1'b0 ##0 $past(rst_i, 3) == 1'b0
    |-> s_r.sync[1] == $past(sink_active_i, 2))
    else $error("synchroniser depth wrong");

  a_rise_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    rise_evt && s_r.rise_en |=> s_r.flag)
    else $error("enabled rising edge lost");

  a_fall_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_evt && s_r.fall_en |=> s_r.flag)
    else $error("enabled falling edge lost");

  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 && adr_i == `FLAGS_OFS && dat_i[`FLAG_BIT] && rise_evt && s_r.rise_en
    |=> s_r.flag)
    else $error("clear beat coincident edge");

  a_no_spurious: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.flag && !(rise_evt && s_r.rise_en) && !(fall_evt && s_r.fall_en)
    |=> !s_r.flag)
    else $error("flag set without enabled edge");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.flag && !(wr0 && adr_i == `FLAGS_OFS && dat_i[`FLAG_BIT]) |=> s_r.flag)
    else $error("flag cleared without software");

  a_irq_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> s_r.flag && s_r.flag_ie && s_r.periph_gate && s_r.global_gate)
    else $error("interrupt without all gates");

  a_edge_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    !(rise_evt && fall_evt))
    else $error("both detectors fired");

  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o ##1 !ack_o)
    else $error("ack not one cycle");

  // ----------------------------------------------------------------
  // bus answer checks
  // ----------------------------------------------------------------

  a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |-> $past(cyc_i && stb_i && !ack_o))
    else $error("ack without request");

  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |=> !ack_o)
    else $error("ack held too long");

  a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i)
    |=> !ack_o)
    else $error("ack while bus idle");

  a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && !we_i)
    |=> $stable(dat_o))
    else $error("read data moved without read");

  a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && !(adr_i inside {`CTRL_OFS, `FLAGS_OFS, `ENABLES_OFS, `IRQCTL_OFS})
    |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_read_status: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && adr_i == `CTRL_OFS
    |=> dat_o[`CTRL_OUT_BIT] == $past(crossing_logic_out_o))
    else $error("status read differs from output");

  a_read_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && adr_i == `FLAGS_OFS
    |=> dat_o[`FLAG_BIT] == $past(s_r.flag))
    else $error("flag read differs from flag");

  a_sel_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.ack && cyc_i && stb_i && we_i && !sel_i[0]
    |=> $stable({s_r.invert, s_r.rise_en, s_r.fall_en, s_r.flag_ie}))
    else $error("write without byte select landed");

  // ----------------------------------------------------------------
  // register write checks
  // ----------------------------------------------------------------

  a_write_en: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 && adr_i == `CTRL_OFS
    |=> s_r.enable == $past(dat_i[`CTRL_EN_BIT]))
    else $error("enable write lost");

  a_write_inv: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 && adr_i == `CTRL_OFS
    |=> s_r.invert == $past(dat_i[`CTRL_INV_BIT]))
    else $error("invert write lost");

  a_write_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 && adr_i == `CTRL_OFS
    |=> s_r.rise_en == $past(dat_i[`CTRL_RISE_BIT]))
    else $error("rise enable write lost");

  a_write_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 && adr_i == `CTRL_OFS
    |=> s_r.fall_en == $past(dat_i[`CTRL_FALL_BIT]))
    else $error("fall enable write lost");

  a_inv_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr0 && adr_i == `CTRL_OFS)
    |=> $stable(s_r.invert))
    else $error("invert changed without write");

  a_edge_en_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr0 && adr_i == `CTRL_OFS)
    |=> $stable({s_r.rise_en, s_r.fall_en}))
    else $error("edge enables changed without write");

  a_strap_load: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.strap_seen
    |=> s_r.enable == !$past(detector_default_off_i))
    else $error("enable default not from strap");

  a_strap_once: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.strap_seen
    |=> s_r.strap_seen)
    else $error("strap sampled twice");

  a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.strap_seen && !(wr0 && adr_i == `CTRL_OFS)
    |=> $stable(s_r.enable))
    else $error("enable changed without write");

  a_write_ie: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 && adr_i == `ENABLES_OFS
    |=> s_r.flag_ie == $past(dat_i[`FLAG_BIT]))
    else $error("flag enable write lost");

  a_write_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 && adr_i == `IRQCTL_OFS
    |=> {s_r.global_gate, s_r.periph_gate} == $past({dat_i[`IRQ_GLOBAL_BIT], dat_i[`IRQ_PERIPH_BIT]}))
    else $error("gate write lost");

  a_gates_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr0 && adr_i inside {`ENABLES_OFS, `IRQCTL_OFS})
    |=> $stable({s_r.flag_ie, s_r.global_gate, s_r.periph_gate}))
    else $error("gates changed without write");

  // ----------------------------------------------------------------
  // event and interrupt checks
  // ----------------------------------------------------------------

  a_sync_first: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> s_r.sync[0] == $past(sink_active_i))
    else $error("first sync stage wrong");

  a_prev_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> s_r.out_prev == $past(crossing_logic_out_o))
    else $error("edge history not the adjusted output");

  a_rise_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.flag && rise_evt && !s_r.rise_en
    |=> !s_r.flag)
    else $error("disabled rising edge set flag");

  a_fall_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.flag && fall_evt && !s_r.fall_en
    |=> !s_r.flag)
    else $error("disabled falling edge set flag");

  a_enable_free: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.enable && fall_evt && s_r.fall_en
    |=> s_r.flag)
    else $error("detection gated by enable");

  a_flag_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.flag && wr0 && adr_i == `FLAGS_OFS && dat_i[`FLAG_BIT] && !rise_evt && !fall_evt
    |=> !s_r.flag)
    else $error("flag clear ignored");

  a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.flag && s_r.flag_ie && s_r.periph_gate && s_r.global_gate
    |-> irq_o)
    else $error("interrupt missing");

  a_irq_global: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.global_gate || !s_r.periph_gate
    |-> !irq_o)
    else $error("interrupt through closed gate");

  a_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.flag && s_r.flag_ie
    |-> wake_o)
    else $error("wake missing");

  a_wake_needs: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o
    |-> s_r.flag && s_r.flag_ie)
    else $error("wake without enabled flag");

endmodule

// ==== ac_wave.sv ====
// behavioural ac waveform source driving the sink-active level
`timescale 1ns/1ps
module ac_wave (
  input wire logic clk_i,
  input wire logic [7:0] half_i,
  input wire logic level_i,
  output logic sink_active_o
);
  logic [7:0] cnt_r;
  logic wrap;
  assign wrap = (cnt_r + 8'h01 >= half_i);
  // follow the commanded level, or toggle every half_i cycles
  always_ff @(posedge clk_i) begin
    cnt_r <= (half_i == 8'h00 || wrap) ? 8'h00 : cnt_r + 8'h01;
    if (half_i == 8'h00) sink_active_o <= level_i;
    else if (wrap) sink_active_o <= ~sink_active_o;
  end
endmodule

// ==== tb.sv ====
// self-checking bench for the crossing detector event logic
`timescale 1ns/1ps
`include "crossing_regs.svh"
module tb;
  logic clk_i = 0, rst_i = 1, strap = 0, cyc = 0, stb = 0, we = 0, lvl = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [7:0] half = 8'h00;
  logic ack, en, lout, irq, wake, sink;
  int err_count = 0, samples_checked = 0;
  initial forever #2 clk_i = ~clk_i;
  ac_wave wave (.clk_i(clk_i), .half_i(half), .level_i(lvl), .sink_active_o(sink));
  zero_crossing_event_logic dut (.clk_i(clk_i), .rst_i(rst_i), .sink_active_i(sink),
    .detector_default_off_i(strap), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .detector_enable_o(en),
    .crossing_logic_out_o(lout), .irq_o(irq), .wake_o(wake));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task summarize();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // classic wishbone single cycle, held until ack is sampled
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin err_count++; summarize(); end
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    wb(0, a, 32'h0);
    chk(q, exp);
  endtask
  task set_lvl(input logic v);
    @(posedge clk_i);
    lvl <= v;
    wait_n(4);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task s_reset();
    wait_n(12);
    rst_i <= 0;
    wait_n(3);
    chk(en, 1);
    rd(`CTRL_OFS, 32'h80);
    rd(4'h2, 32'h0);
  endtask
  task s_polarity();
    set_lvl(1);
    chk(lout, 1);
    wb(1, `CTRL_OFS, 32'h10);
    wait_n(2);
    chk(lout, 0);
    rd(`CTRL_OFS, 32'h10);
    rd(`FLAGS_OFS, 32'h0);
  endtask
  task s_edges();
    wb(1, `CTRL_OFS, 32'h02);
    wait_n(3);
    rd(`FLAGS_OFS, 32'h40);
    wb(1, `FLAGS_OFS, 32'h40);
    rd(`FLAGS_OFS, 32'h0);
    set_lvl(0);
    rd(`FLAGS_OFS, 32'h0);
    set_lvl(1);
    rd(`FLAGS_OFS, 32'h40);
    wb(1, `CTRL_OFS, 32'h11);
    wait_n(3);
    wb(1, `FLAGS_OFS, 32'h40);
    set_lvl(0);
    rd(`FLAGS_OFS, 32'h0);
    set_lvl(1);
    rd(`FLAGS_OFS, 32'h40);
  endtask
  task s_irq();
    wb(1, `ENABLES_OFS, 32'h40);
    wait_n(2);
    chk({irq, wake}, 2'b01);
    wb(1, `IRQCTL_OFS, 32'h40);
    wait_n(2);
    chk(irq, 0);
    wb(1, `IRQCTL_OFS, 32'hc0);
    wait_n(2);
    chk(irq, 1);
    wb(1, `FLAGS_OFS, 32'h40);
    wait_n(2);
    chk({irq, wake}, 2'b00);
    half <= 8'h05;
    wait_n(30);
    chk(irq, 1);
  endtask
  task s_race();
    @(posedge clk_i);
    half <= 8'h00;
    lvl <= 0;
    wait_n(6);
    wb(1, `CTRL_OFS, 32'h02);
    wait_n(3);
    wb(1, `FLAGS_OFS, 32'h40);
    rd(`FLAGS_OFS, 32'h0);
    @(posedge clk_i);
    lvl <= 1;
    @(posedge clk_i);
    wb(1, `FLAGS_OFS, 32'h40);
    rd(`FLAGS_OFS, 32'h40);
  endtask
  task s_strap();
    @(posedge clk_i);
    rst_i <= 1;
    strap <= 1;
    wait_n(3);
    rst_i <= 0;
    wait_n(3);
    chk(en, 0);
    chk({irq, wake}, 2'b00);
    rd(`CTRL_OFS, 32'h20);
    wb(1, `CTRL_OFS, 32'h80);
    rd(`CTRL_OFS, 32'ha0);
  endtask
  initial begin
    s_reset();
    s_polarity();
    s_edges();
    s_irq();
    s_race();
    s_strap();
    summarize();
  end
endmodule
